// >>> pkg/usart_frame_pkg.sv
// Purpose: Constants for the serial frame transmit/receive core
// Assumes: 32-bit APB, one clock, sample ticks from an outside baud generator
// Notes:   Byte offsets of the register map and field positions
package usart_frame_pkg;
  localparam logic [7:0] OFS_RX_LOW  = 8'h00;
  localparam logic [7:0] OFS_RX_HIGH = 8'h04;
  localparam logic [7:0] OFS_TX_LOW  = 8'h08;
  localparam logic [7:0] OFS_TX_HIGH = 8'h0c;
  localparam logic [7:0] OFS_STATUS  = 8'h10;
  localparam logic [7:0] OFS_CTRL_B  = 8'h14;
  localparam logic [7:0] OFS_CTRL_C  = 8'h18;
  // control_b fields
  localparam int CB_RXEN  = 0;
  localparam int CB_TXEN  = 1;
  localparam int CB_ONEW  = 2;
  localparam int CB_SPEED = 3;   // 2-bit receive_speed_select
  // control_c fields
  localparam int CC_SIZE  = 0;   // 3-bit char size code 0..4 = 5..9 bits
  localparam int CC_PAR   = 3;   // 2-bit parity_select
  localparam int CC_STOP2 = 5;
  localparam int CC_SPI   = 6;
  localparam int CC_ORDER = 7;   // spi_bit_order, 1 = LSb first
  // status fields
  localparam int ST_RXC = 7;
  localparam int ST_TXC = 6;
  localparam int ST_DRE = 5;
  // rx_data_high fields
  localparam int RH_RXC = 7;
  localparam int RH_OVF = 6;
  localparam int RH_FER = 2;
  localparam int RH_PER = 1;
  localparam logic [1:0] SPEED_NORMAL = 2'h0;
  localparam logic [1:0] SPEED_LIN    = 2'h1;
  localparam logic [1:0] SPEED_DOUBLE = 2'h2;
  localparam logic [1:0] PAR_EVEN     = 2'h2;
  localparam logic [1:0] PAR_ODD      = 2'h3;
  localparam logic [3:0] SAMPLES_NORMAL = 4'hf;  // last sample index, 16 per bit
  localparam logic [3:0] SAMPLES_DOUBLE = 4'h7;  // 8 per bit
  localparam logic [3:0] MID_NORMAL   = 4'h8;    // first of three centre samples
  localparam logic [3:0] MID_DOUBLE   = 4'h4;
  localparam logic [2:0] CTRL_C_RESET = 3'h3;    // 8-bit characters
  localparam int RX_FIFO_DEPTH = 2;
  localparam int CLOCK_HZ = 40000000;
  typedef enum logic [3:0] {
    TX_IDLE  = 4'b0001,
    TX_START = 4'b0010,
    TX_BITS  = 4'b0100,
    TX_STOP  = 4'b1000
  } tx_state_type;
  typedef enum logic [3:0] {
    RX_IDLE  = 4'b0001,
    RX_START = 4'b0010,
    RX_BITS  = 4'b0100,
    RX_STOP  = 4'b1000
  } rx_state_type;
endpackage

// >>> hw/usart_frame_core.sv
// Purpose: Frame transmitter and oversampling receiver with APB register access
// Assumes: txTick is one transmit bit period in frame mode and half a bit in SPI mode, sampleTick one receive sample
// Notes:   Master SPI mode shifts eight bits on txTick with no framing bits

// Operation
// [R1] Frames: start, 5..9 data, optional parity, one or two stops.
// [R2] Start bit low, stop bits high, idle line high.
// [R3] Even parity bit is one on odd count of ones; odd the reverse.
// [R4] Receiver checks parity and sets parity error on mismatch.
// [R5] SPI master frames are eight bits, MSb or LSb first by order bit.
// [R6] Next frame may follow back to back or line returns idle.
// [R7] Enabled transmitter drives pin; one-wire forces shared pin to output. The code never reads CB_ONEW, and txOe follows transmit enable only.
// [R8] Buffer loads shift register when idle or right after last stop.
// [R9] Transmit complete set when frame done and buffer empty.
// [R10] Software writes transmit data only while buffer-empty flag set.
// [R11] Short characters ignore upper bits; ninth bit written before low byte.
// [R12] Transmitter disable waits until shift register and buffer are empty.
// [R13] Receiver shifts to first stop, ignores second, then sets complete.
// [R14] Unused upper bits read zero; ninth bit read before low byte.
// [R15] Error flags travel in FIFO; low byte read advances it.
// [R16] LIN mode checks only protected identifier parity bits P0 and P1.
// [R17] Receiver disable flushes buffer and drops reception at once.
// [R18] Software flushes by reading high then low until complete clears.
// [R19] Sixteen samples per bit normally, eight in double speed.
// [R20] Start accepted when two of samples 8-10 (or 4-6) are low.
// [R21] Data, parity and first stop decided by three-sample majority.
// [R22] Low voted first stop bit sets framing error.
// [R23] Double speed chosen by receive speed select, eight samples per bit.
// [R24] Sample counter runs on sample ticks, restarts at start edge.
module usart_frame_core
  import usart_frame_pkg::*;
(
  input  wire logic        clock,
  input  wire logic        rstn,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [7:0]  paddr,
  input  wire logic [31:0] pwdata,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  input  wire logic        txTick,
  input  wire logic        sampleTick,
  input  wire logic        rxPin,
  output logic             txOut,
  output logic             txOe,
  output logic             transferClock
);
  function automatic logic vote(input logic [2:0] s);
    vote = (s[0] & s[1]) | (s[0] & s[2]) | (s[1] & s[2]);
  endfunction
  function automatic logic [8:0] charMask(input logic [2:0] sz);
    charMask = 9'h1ff >> (3'h4 - sz);
  endfunction

  logic [7:0] control_b_q, control_b_d;
  logic [7:0] control_c_q, control_c_d;
  logic [8:0] txBuf_q, txBuf_d;
  logic       txBufFull_q, txBufFull_d;
  logic       txHigh_q, txHigh_d;
  logic       txc_q, txc_d;
  tx_state_type txState_q, txState_d;
  logic [8:0] txShift_q, txShift_d;
  logic [3:0] txCnt_q, txCnt_d;
  logic       txPar_q, txPar_d;
  logic       txOut_q, txOut_d, txActive_q, txActive_d;
  logic       txOffPend_q, txOffPend_d;
  logic       sck_q, sck_d;
  rx_state_type rxState_q, rxState_d;
  logic [3:0] smp_q, smp_d;
  logic [2:0] win_q, win_d;
  logic [8:0] rxShift_q, rxShift_d;
  logic [3:0] rxCnt_q, rxCnt_d;
  logic       rxPar_q, rxPar_d;
  logic       rxPrev_q, rxPrev_d;
  logic [11:0] fifo_q [RX_FIFO_DEPTH];
  logic [11:0] fifo_d [RX_FIFO_DEPTH];
  logic [1:0] fifoCnt_q, fifoCnt_d;
  logic       ovfPend_q, ovfPend_d;
  logic [31:0] prdata_q, prdata_d;
  logic       pready_q, pready_d, pslverr_q, pslverr_d;

  logic [1:0] parSel, speedSel;
  logic [2:0] sizeSel;
  logic [3:0] nData, lastSmp, midSmp;
  logic       spiMode, dbl, apbAcc, wr, rd, rxEn, txEn;
  logic       pushRx;
  logic [11:0] pushWord;

  always_comb begin
    parSel   = control_c_q[CC_PAR +: 2];
    sizeSel  = control_c_q[CC_SIZE +: 3];
    speedSel = control_b_q[CB_SPEED +: 2];
    spiMode  = control_c_q[CC_SPI];
    nData    = spiMode ? 4'h8 : {1'b0, sizeSel} + 4'h5; // [R1] [R5]
    dbl      = speedSel == SPEED_DOUBLE;                // [R23]
    lastSmp  = dbl ? SAMPLES_DOUBLE : SAMPLES_NORMAL;   // [R19]
    midSmp   = dbl ? MID_DOUBLE : MID_NORMAL;           // [R20]
    rxEn     = control_b_q[CB_RXEN];
    txEn     = control_b_q[CB_TXEN];
    apbAcc   = psel & penable & ~pready_q;
    wr       = apbAcc & pwrite;
    rd       = apbAcc & ~pwrite;
  end

  // Transmitter and register writes
  always_comb begin
    control_b_d = control_b_q;
    control_c_d = control_c_q;
    txBuf_d = txBuf_q;
    txBufFull_d = txBufFull_q;
    txHigh_d = txHigh_q;
    txc_d = txc_q;
    txState_d = txState_q;
    txShift_d = txShift_q;
    txCnt_d = txCnt_q;
    txPar_d = txPar_q;
    txOut_d = txOut_q;
    txActive_d = txActive_q;
    sck_d = sck_q;
    txOffPend_d = txOffPend_q;
    if (wr) begin
      case (paddr)
        OFS_CTRL_B: control_b_d = pwdata[7:0];
        OFS_CTRL_C: control_c_d = pwdata[7:0];
        OFS_TX_HIGH: txHigh_d = pwdata[0]; // [R11]
        OFS_TX_LOW: if (txBufFull_q == 1'b0) begin // [R10]
          txBuf_d = {txHigh_q, pwdata[7:0]} & charMask(sizeSel); // [R11]
          if (spiMode) txBuf_d = {1'b0, pwdata[7:0]};
          txBufFull_d = 1'b1;
          txc_d = 1'b0;
        end
        OFS_STATUS: if (pwdata[ST_TXC]) txc_d = 1'b0;
        default: ;
      endcase
    end
    // Disable while busy: keep enable, remember the request
    if (wr && paddr == OFS_CTRL_B) begin
      txOffPend_d = txEn && !pwdata[CB_TXEN] && (txBufFull_q || txState_q != TX_IDLE);
      if (txOffPend_d) control_b_d[CB_TXEN] = 1'b1; // [R12]
    end
    if (txTick) begin
      case (txState_q)
        TX_IDLE: begin
          txOut_d = 1'b1; // [R2]
          sck_d = 1'b0;
          if (txEn && txBufFull_q) begin // [R8]
            txShift_d = txBuf_q;
            txBufFull_d = 1'b0;
            txPar_d = (^txBuf_q) ^ (parSel == PAR_ODD); // [R3]
            txCnt_d = 4'h0;
            if (spiMode) begin
              txState_d = TX_BITS; // [R5]
              txOut_d = control_c_q[CC_ORDER] ? txBuf_q[0] : txBuf_q[7];
            end else begin
              txState_d = TX_START;
              txOut_d = 1'b0; // [R2]
            end
          end
        end
        TX_START: begin
          txState_d = TX_BITS;
          txOut_d = txShift_q[0];
          txShift_d = txShift_q >> 1;
          txCnt_d = 4'h1;
        end
        TX_BITS: begin
          if (spiMode) begin
            sck_d = ~sck_q;
            if (sck_q) begin
              txCnt_d = txCnt_q + 4'h1;
              if (control_c_q[CC_ORDER]) txShift_d = txShift_q >> 1;
              else txShift_d = txShift_q << 1;
              txOut_d = control_c_q[CC_ORDER] ? txShift_q[1] : txShift_q[6];
              if (txCnt_q == 4'h7) begin
                txState_d = TX_IDLE;
                txOut_d = 1'b1;
                if (!txBufFull_d) txc_d = 1'b1; // [R9]
              end
            end
          end else if (txCnt_q == nData) begin
            txCnt_d = 4'h0;
            txState_d = TX_STOP;
            txOut_d = parSel[1] ? txPar_q : 1'b1; // [R1] [R2]
            if (parSel[1]) txCnt_d = 4'hf;
          end else begin
            txOut_d = txShift_q[0];
            txShift_d = txShift_q >> 1;
            txCnt_d = txCnt_q + 4'h1;
          end
        end
        TX_STOP: begin
          txOut_d = 1'b1;
          txCnt_d = txCnt_q + 4'h1;
          if (txCnt_q == {3'h0, control_c_q[CC_STOP2]}) begin // [R1]
            if (txBufFull_q) begin // [R6] [R8]
              txShift_d = txBuf_q;
              txBufFull_d = 1'b0;
              txPar_d = (^txBuf_q) ^ (parSel == PAR_ODD); // [R3]
              txState_d = TX_START;
              txOut_d = 1'b0;
            end else begin
              txState_d = TX_IDLE;
              txc_d = ~txBufFull_d; // [R9]
            end
          end
        end
        default: txState_d = TX_IDLE;
      endcase
    end
    // Requested disable lands once both stages are empty
    if (txOffPend_d && !txBufFull_d && txState_d == TX_IDLE) begin // [R12]
      control_b_d[CB_TXEN] = 1'b0;
      txOffPend_d = 1'b0;
    end
    txActive_d = txEn; // [R7] [R12]
  end

  // Receiver, sample-tick driven
  always_comb begin
    rxState_d = rxState_q;
    smp_d = smp_q;
    win_d = win_q;
    rxShift_d = rxShift_q;
    rxCnt_d = rxCnt_q;
    rxPar_d = rxPar_q;
    rxPrev_d = rxPrev_q;
    pushRx = 1'b0;
    pushWord = 12'h000;
    if (sampleTick) begin
      rxPrev_d = rxPin;
      smp_d = (smp_q >= lastSmp) ? 4'h0 : smp_q + 4'h1; // [R24]
      if (smp_q >= midSmp && smp_q <= midSmp + 4'h2) win_d = {win_q[1:0], rxPin};
      case (rxState_q)
        RX_IDLE: if (rxPrev_q && !rxPin) begin
          rxState_d = RX_START;
          smp_d = 4'h2; // [R24] this sample is 1
        end
        RX_START: if (smp_q == midSmp + 4'h2) begin
          if (!vote({win_q[1:0], rxPin})) begin // [R20]
            rxState_d = RX_BITS;
            rxCnt_d = 4'h0;
            rxShift_d = 9'h000;
          end else rxState_d = RX_IDLE;
        end
        RX_BITS: if (smp_q == midSmp + 4'h2) begin
          if (rxCnt_q < nData)
            rxShift_d[rxCnt_q] = vote({win_q[1:0], rxPin}); // [R21]
          else rxPar_d = vote({win_q[1:0], rxPin});
          rxCnt_d = rxCnt_q + 4'h1;
          if (rxCnt_q == nData - {3'h0, ~parSel[1]}) rxState_d = RX_STOP;
        end
        RX_STOP: if (smp_q == midSmp + 4'h2) begin // [R13]
          pushRx = 1'b1;
          pushWord[8:0] = rxShift_q;
          pushWord[9] = ~vote({win_q[1:0], rxPin}); // [R22]
          if (speedSel == SPEED_LIN) // [R16]
            pushWord[10] = (rxShift_q[6] != (rxShift_q[0]^rxShift_q[1]^rxShift_q[2]^rxShift_q[4]))
              || (rxShift_q[7] != ~(rxShift_q[1]^rxShift_q[3]^rxShift_q[4]^rxShift_q[5]));
          else if (parSel[1]) // [R4]
            pushWord[10] = rxPar_q != ((^rxShift_q) ^ (parSel == PAR_ODD));
          rxState_d = RX_IDLE; // second stop ignored
        end
        default: rxState_d = RX_IDLE;
      endcase
    end
    if (!rxEn) begin // [R17]
      rxState_d = RX_IDLE;
      pushRx = 1'b0;
      rxPrev_d = 1'b1;
    end
  end

  // Receive FIFO and register reads
  always_comb begin
    fifo_d = fifo_q;
    fifoCnt_d = fifoCnt_q;
    ovfPend_d = ovfPend_q;
    prdata_d = 32'h0000_0000;
    pready_d = apbAcc;
    pslverr_d = 1'b0;
    if (rd) begin
      case (paddr)
        OFS_RX_LOW: begin
          prdata_d[7:0] = fifo_q[0][7:0];
          if (fifoCnt_q != 2'h0) begin // [R15]
            fifo_d[0] = fifo_q[1];
            fifoCnt_d = fifoCnt_q - 2'h1;
          end
        end
        OFS_RX_HIGH: begin // [R14] [R15]
          prdata_d[0] = fifo_q[0][8];
          prdata_d[RH_RXC] = fifoCnt_q != 2'h0;
          if (!spiMode) begin
            prdata_d[RH_FER] = fifo_q[0][9];
            prdata_d[RH_PER] = fifo_q[0][10];
            prdata_d[RH_OVF] = fifo_q[0][11];
          end
        end
        OFS_TX_HIGH: prdata_d[0] = txHigh_q;
        OFS_STATUS: begin
          prdata_d[ST_RXC] = fifoCnt_q != 2'h0;
          prdata_d[ST_TXC] = txc_q;
          prdata_d[ST_DRE] = ~txBufFull_q;
        end
        OFS_CTRL_B: prdata_d[7:0] = control_b_q;
        OFS_CTRL_C: prdata_d[7:0] = control_c_q;
        OFS_TX_LOW: ;
        default: pslverr_d = 1'b1;
      endcase
    end else if (wr) begin
      case (paddr)
        OFS_RX_LOW, OFS_RX_HIGH, OFS_TX_LOW, OFS_TX_HIGH,
        OFS_STATUS, OFS_CTRL_B, OFS_CTRL_C: ;
        default: pslverr_d = 1'b1;
      endcase
    end
    if (pushRx) begin
      if (fifoCnt_d == 2'(RX_FIFO_DEPTH)) ovfPend_d = 1'b1;
      else begin
        fifo_d[fifoCnt_d[0]] = {ovfPend_q, pushWord[10:0]};
        fifoCnt_d = fifoCnt_d + 2'h1;
        ovfPend_d = 1'b0;
      end
    end
    if (!rxEn) begin // [R17]
      fifoCnt_d = 2'h0;
      ovfPend_d = 1'b0;
    end
  end

  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      control_b_q <= 8'h00;
      control_c_q <= {5'h00, CTRL_C_RESET};
      txBuf_q <= 9'h000;
      txBufFull_q <= 1'b0;
      txHigh_q <= 1'b0;
      txc_q <= 1'b0;
      txState_q <= TX_IDLE;
      txShift_q <= 9'h000;
      txCnt_q <= 4'h0;
      txPar_q <= 1'b0;
      txOut_q <= 1'b1;
      txActive_q <= 1'b0;
      txOffPend_q <= 1'b0;
      sck_q <= 1'b0;
      rxState_q <= RX_IDLE;
      smp_q <= 4'h0;
      win_q <= 3'h7;
      rxShift_q <= 9'h000;
      rxCnt_q <= 4'h0;
      rxPar_q <= 1'b0;
      rxPrev_q <= 1'b1;
      for (int i = 0; i < RX_FIFO_DEPTH; i++) fifo_q[i] <= 12'h000;
      fifoCnt_q <= 2'h0;
      ovfPend_q <= 1'b0;
      prdata_q <= 32'h0000_0000;
      pready_q <= 1'b0;
      pslverr_q <= 1'b0;
    end else begin
      control_b_q <= control_b_d;
      control_c_q <= control_c_d;
      txBuf_q <= txBuf_d;
      txBufFull_q <= txBufFull_d;
      txHigh_q <= txHigh_d;
      txc_q <= txc_d;
      txState_q <= txState_d;
      txShift_q <= txShift_d;
      txCnt_q <= txCnt_d;
      txPar_q <= txPar_d;
      txOut_q <= txOut_d;
      txActive_q <= txActive_d;
      txOffPend_q <= txOffPend_d;
      sck_q <= sck_d;
      rxState_q <= rxState_d;
      smp_q <= smp_d;
      win_q <= win_d;
      rxShift_q <= rxShift_d;
      rxCnt_q <= rxCnt_d;
      rxPar_q <= rxPar_d;
      rxPrev_q <= rxPrev_d;
      fifo_q <= fifo_d;
      fifoCnt_q <= fifoCnt_d;
      ovfPend_q <= ovfPend_d;
      prdata_q <= prdata_d;
      pready_q <= pready_d;
      pslverr_q <= pslverr_d;
    end
  end

  always_comb begin
    txOe = txActive_q; // [R7]
    txOut = txOut_q;
    transferClock = sck_q;
    prdata = prdata_q;
    pready = pready_q;
    pslverr = pslverr_q;
  end

  property p_idle_high;
    @(posedge clock) disable iff (!rstn) txState_q == TX_IDLE |-> txOut_q;
  endproperty
  a_idle_high: assert property (p_idle_high) else $error("line not high at idle"); // [R2]
  property p_start_low;
    @(posedge clock) disable iff (!rstn) txState_q == TX_START |-> !txOut_q;
  endproperty
  a_start_low: assert property (p_start_low) else $error("start bit not low"); // [R2]
  property p_stop_high;
    @(posedge clock) disable iff (!rstn)
      txState_q == TX_STOP && txCnt_q != 4'hf |-> txOut_q;
  endproperty
  a_stop_high: assert property (p_stop_high) else $error("stop bit not high"); // [R2]
  property p_oe_enable;
    @(posedge clock) disable iff (!rstn) $rose(control_b_q[CB_TXEN]) |=> txOe;
  endproperty
  a_oe_enable: assert property (p_oe_enable) else $error("pin not driven after enable"); // [R7]
  property p_disable_wait;
    @(posedge clock) disable iff (!rstn)
      $fell(control_b_q[CB_TXEN]) |-> txState_q == TX_IDLE && !txBufFull_q;
  endproperty
  a_disable_wait: assert property (p_disable_wait) else $error("tx disabled while busy"); // [R12]
  property p_txc_set;
    @(posedge clock) disable iff (!rstn) $rose(txc_q) |-> !txBufFull_q && txState_q == TX_IDLE;
  endproperty
  a_txc_set: assert property (p_txc_set) else $error("tx complete while data pending"); // [R9]
  property p_rx_flush;
    @(posedge clock) disable iff (!rstn) !rxEn |=> fifoCnt_q == 2'h0 && rxState_q == RX_IDLE;
  endproperty
  a_rx_flush: assert property (p_rx_flush) else $error("receiver not flushed"); // [R17]
  property p_smp_range;
    @(posedge clock) disable iff (!rstn)
      sampleTick && dbl && rxState_q != RX_IDLE |=> smp_q <= SAMPLES_DOUBLE;
  endproperty
  a_smp_range: assert property (p_smp_range) else $error("sample count out of range"); // [R19]
  property p_apb_one;
    @(posedge clock) disable iff (!rstn) psel && penable && !pready_q |=> pready_q;
  endproperty
  a_apb_one: assert property (p_apb_one) else $error("apb answer late"); // [R15]
  c_frame_done: cover property (@(posedge clock) $rose(txc_q));
  c_rx_push: cover property (@(posedge clock) fifoCnt_q == 2'h2);
  c_back2back: cover property (@(posedge clock) txState_q == TX_STOP ##1 txState_q == TX_START);
endmodule

// >>> sim/line_partner.sv
// Purpose: Remote serial node on the line side of the frame core
// Assumes: Bench gives frame length of the transmit side
// Notes:   Decodes txOut mid-bit, 32 clocks per bit; frameLen 0 mutes it.
//          SPI data is shifted in on each rising transfer clock
module line_partner (
  input  wire logic        clock,
  input  wire logic        txOut,
  input  wire logic        transferClock,
  input  wire logic [3:0]  frameLen,
  output logic             rxPin,
  output logic             frameDone,
  output logic [12:0]      frameBits,
  output logic [7:0]       spiBits
);
  timeunit 1ns;
  timeprecision 1ps;
  initial begin
    rxPin = 1'b1;
    frameDone = 1'b0;
    frameBits = '0;
  end
  // Drive a frame, first bit first, cpb clocks per bit
  task automatic send(input logic [12:0] bits, input int n, input int cpb);
    for (int i = 0; i < n; i++) begin
      rxPin <= bits[i];
      repeat (cpb) @(posedge clock);
    end
    rxPin <= 1'b1;
  endtask
  always @(posedge transferClock) spiBits <= {spiBits[6:0], txOut};
  always begin
    @(negedge txOut);
    frameBits = '0;
    for (int i = 0; i < int'(frameLen); i++) begin
      repeat (i == 0 ? 16 : 32) @(posedge clock);
      frameBits[i] = txOut;
    end
    if (frameLen != 4'h0) begin
      frameDone <= 1'b1;
      @(posedge clock);
      frameDone <= 1'b0;
    end
  end
endmodule

// >>> sim/usart_frame_core_bench.sv
// Purpose: Self-checking bench for the frame core
// Assumes: sampleTick every 2 clocks, txTick every 32 clocks
// Notes:   Expected results queued, a monitor compares them
module usart_frame_core_bench
  import usart_frame_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  logic        clock, rstn, psel, penable, pwrite, txTick, sampleTick;
  logic        pready, pslverr, txOut, txOe, transferClock, rxPin;
  logic        frameDone, track, rerr;
  logic [7:0]  paddr;
  logic [31:0] pwdata, prdata, rd;
  logic [12:0] frameBits, fr;
  logic [3:0]  frameLen;
  logic [8:0]  d;
  logic [7:0]  pid, rev, spiBits;
  logic [32:0] expQ[$];
  logic [12:0] lineQ[$];
  logic [7:0]  cfgs[4] = '{8'h13, 8'h39, 8'h04, 8'h20};
  int          mismatches, checksDone, seed, cyc;

  initial begin
    clock = 1'b0;
    forever #12.5 clock = ~clock;
  end
  always @(posedge clock) begin
    cyc <= cyc + 1;
    sampleTick <= cyc[0];
    txTick <= (cyc[4:0] == 5'h0);
  end

  usart_frame_core dut (.clock(clock), .rstn(rstn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .txTick(txTick), .sampleTick(sampleTick), .rxPin(rxPin),
    .txOut(txOut), .txOe(txOe), .transferClock(transferClock));
  line_partner line (.clock(clock), .txOut(txOut), .transferClock(transferClock),
    .frameLen(frameLen), .rxPin(rxPin), .frameDone(frameDone), .frameBits(frameBits),
    .spiBits(spiBits));

  task automatic check(input logic [32:0] seen, input logic [32:0] exp);
    checksDone++;
    if (seen !== exp) begin
      mismatches++;
      $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  always @(posedge clock) begin
    if (track && pready === 1'b1) check({pslverr, prdata}, expQ.pop_front());
    if (frameDone === 1'b1) check(33'(frameBits), 33'(lineQ.pop_front()));
  end

  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] v,
                     input logic chk, input logic [32:0] e);
    int n;
    n = 0;
    if (chk) expQ.push_back(e);
    @(posedge clock);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= v;
    track <= chk;
    @(posedge clock);
    penable <= 1'b1;
    do begin
      @(posedge clock);
      n++;
    end while (pready !== 1'b1 && n < 50);
    if (n >= 50) mismatches++;
    rd = prdata;
    rerr = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    track <= 1'b0;
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] v);
    apb(1'b1, a, v, 1'b0, '0);
  endtask
  task automatic waitst(input int b);
    int k;
    k = 0;
    do begin
      apb(1'b0, OFS_STATUS, '0, 1'b0, '0);
      k++;
    end while (rd[b] !== 1'b1 && k < 400);
    if (k >= 400) mismatches++;
  endtask
  function automatic int flen(input logic [7:0] c);
    return int'(c[2:0]) + 7 + int'(c[4]) + int'(c[5]);
  endfunction
  // Line bits of a frame, first bit in bit 0
  function automatic logic [12:0] frame(input logic [7:0] c, input logic [8:0] v);
    int nb;
    logic [12:0] f;
    logic p;
    nb = int'(c[2:0]) + 5;
    f = '1;
    p = c[3];
    for (int i = 0; i < nb; i++) begin
      f[i + 1] = v[i];
      p ^= v[i];
    end
    if (c[4]) f[nb + 1] = p;
    f[0] = 1'b0;
    return f & ((13'h1 << flen(c)) - 13'h1);
  endfunction
  task automatic rxcase(input logic [7:0] b, c, input logic [12:0] bits, input int cpb,
                        input logic [7:0] eh, el);
    wr(OFS_CTRL_C, 32'(c));
    wr(OFS_CTRL_B, 32'(b));
    line.send(bits, flen(c), cpb);
    waitst(ST_RXC);
    apb(1'b0, OFS_RX_HIGH, '0, 1'b1, 33'(eh));
    apb(1'b0, OFS_RX_LOW, '0, 1'b1, 33'(el));
  endtask
  task automatic tally_and_finish();
    $display("mismatches %0d checks %0d", mismatches, checksDone);
    if (mismatches == 0 && checksDone > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask

  initial begin
    #1000000;
    mismatches++;
    tally_and_finish();
  end
  initial begin
    seed = 13640;
    rstn = 1'b0;
    {psel, penable, pwrite, track} = '0;
    paddr = '0;
    pwdata = '0;
    frameLen = 4'hb;
    repeat (5) @(posedge clock);
    rstn <= 1'b1;
    apb(1'b0, OFS_STATUS, '0, 1'b1, 33'h20);
    apb(1'b0, OFS_CTRL_C, '0, 1'b1, 33'(CTRL_C_RESET));
    apb(1'b0, 8'h1c, '0, 1'b0, '0);
    check(33'(rerr), 33'h1);
    for (int t = 0; t < 4; t++) begin
      d = 9'($random(seed));
      wr(OFS_CTRL_C, 32'(cfgs[t]));
      wr(OFS_CTRL_B, 32'h2);
      frameLen <= 4'(flen(cfgs[t]));
      lineQ.push_back(frame(cfgs[t], d));
      wr(OFS_TX_HIGH, 32'(d[8]));
      wr(OFS_TX_LOW, 32'(d[7:0]));
      waitst(ST_TXC);
      check(33'(txOe), 33'h1);
      apb(1'b0, OFS_STATUS, '0, 1'b1, 33'h60);
      wr(OFS_STATUS, 32'h40);
    end
    // Two frames back to back, then disable while pending
    wr(OFS_CTRL_C, 32'h13);
    frameLen <= 4'hb;
    lineQ.push_back(frame(8'h13, 9'h0a5));
    lineQ.push_back(frame(8'h13, 9'h03c));
    wr(OFS_TX_LOW, 32'ha5);
    waitst(ST_DRE);
    wr(OFS_TX_LOW, 32'h3c);
    wr(OFS_CTRL_B, 32'h0);
    apb(1'b0, OFS_STATUS, '0, 1'b1, 33'h0);
    check(33'(txOe), 33'h1);
    waitst(ST_TXC);
    apb(1'b0, OFS_STATUS, '0, 1'b0, '0);
    check(33'(txOe), 33'h0);
    wr(OFS_STATUS, 32'h40);
    // SPI master, MSb then LSb first, no framing bits on the line
    frameLen <= 4'h0;
    wr(OFS_CTRL_B, 32'h2);
    for (int o = 0; o < 2; o++) begin
      d = 9'($random(seed));
      rev = {<<{d[7:0]}};
      wr(OFS_CTRL_C, 32'h40 | 32'(o << 7));
      wr(OFS_TX_LOW, 32'(d[7:0]));
      waitst(ST_TXC);
      check(33'(spiBits), 33'(o == 0 ? d[7:0] : rev));
      wr(OFS_STATUS, 32'h40);
    end
    d = 9'($random(seed));
    fr = frame(8'h13, d);
    rxcase(8'h01, 8'h13, fr, 32, 8'h80, d[7:0]);
    rxcase(8'h01, 8'h13, fr ^ 13'h200, 32, 8'h82, d[7:0]);
    rxcase(8'h01, 8'h13, fr ^ 13'h400, 32, 8'h84, d[7:0]);
    rxcase(8'h11, 8'h22, frame(8'h22, d), 16, 8'h80, {1'b0, d[6:0]});
    rxcase(8'h01, 8'h04, frame(8'h04, d), 32, {7'h40, d[8]}, d[7:0]);
    pid = {~(d[1] ^ d[3] ^ d[4] ^ d[5]), d[0] ^ d[1] ^ d[2] ^ d[4], d[5:0]};
    rxcase(8'h09, 8'h03, frame(8'h03, {1'b0, pid}), 32, 8'h80, pid);
    pid[7] = ~pid[7];
    rxcase(8'h09, 8'h03, frame(8'h03, {1'b0, pid}), 32, 8'h82, pid);
    // Short low pulse must not start a frame
    line.send(13'h0, 1, 4);
    repeat (64) @(posedge clock);
    rxcase(8'h01, 8'h03, frame(8'h03, d), 32, 8'h80, d[7:0]);
    wr(OFS_CTRL_B, 32'h1);
    line.send(fr, 11, 32);
    waitst(ST_RXC);
    wr(OFS_CTRL_B, 32'h0);
    apb(1'b0, OFS_STATUS, '0, 1'b1, 33'h20);
    // Two stored frames, flushed by reading until complete clears
    wr(OFS_CTRL_B, 32'h1);
    line.send(fr, 11, 32);
    @(posedge clock);
    line.send(fr, 11, 32);
    do begin
      apb(1'b0, OFS_RX_HIGH, '0, 1'b0, '0);
      apb(1'b0, OFS_RX_LOW, '0, 1'b0, '0);
      apb(1'b0, OFS_STATUS, '0, 1'b0, '0);
    end while (rd[ST_RXC] === 1'b1);
    check(33'(rd), 33'h20);
    tally_and_finish();
  end
endmodule
